/* rtl/bp_debugger.sv */
// Debugger controller: APB registers that program the breakpoint unit.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module bp_debugger
	import bp_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Interrupt
	output logic             irq,
	// Breakpoint unit link
	bp_link_if.host          link
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	host_state_e st_q, st_d;
	logic        pready_q, pready_d;
	logic [31:0] prdata_q, prdata_d;
	logic        err_q, err_d;
	logic        gen_q, gen_d;
	logic [4:0]  cmd_q, cmd_d;
	logic [31:0] wdat_q, wdat_d;
	logic [31:0] rdat_q, rdat_d;
	logic [2:0]  ist_q, ist_d;
	logic [2:0]  imask_q, imask_d;
	logic [5:0]  hits_q, hits_d;
	logic [5:0]  wrote_q, wrote_d;
	logic        irq_q, irq_d;
	logic        dben_q, dben_d;
	logic        acc;
	logic        wr;
	logic        mapped;

	// Control words are made legal before they leave.
	function automatic logic [31:0] legal(input logic [31:0] c);
		logic [31:0] r;
		r = c;
		if (!is_linked_addr(r))
			r[LINK_LSB +: 4] = 4'h0;
		if (bp_type(r) == TYPE_LCTX) begin
			r[SEC_LSB +: 2]  = 2'h0;
			r[HYP_BIT]       = 1'b0;
			r[PRIV_LSB +: 2] = 2'h3;
		end
		if (bp_type(r) == TYPE_CTX || bp_type(r) == TYPE_LCTX || r[MASK_LSB +: 5] != 5'h00)
			r[LANE_LSB +: 4] = 4'hF;
		return r;
	endfunction

	assign acc    = psel && penable && pready_q;
	assign wr     = acc && pwrite;
	assign mapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_HITS);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [2:0] set;
		set      = 3'h0;
		st_d     = st_q;
		pready_d = psel && penable && !pready_q;
		prdata_d = prdata_q;
		err_d    = psel && penable && !pready_q && !mapped;
		gen_d    = gen_q;
		cmd_d    = cmd_q;
		wdat_d   = wdat_q;
		rdat_d   = rdat_q;
		imask_d  = imask_q;
		hits_d   = link.event_hit ? link.hits : hits_q;
		wrote_d  = wrote_q;
		if (psel && penable && !pready_q && !pwrite) begin
			case (paddr)
				OFS_CTRL:     prdata_d = {31'h0, gen_q};
				OFS_CMD:      prdata_d = {27'h0, cmd_q};
				OFS_WDATA:    prdata_d = wdat_q;
				OFS_RDATA:    prdata_d = rdat_q;
				OFS_STATUS:   prdata_d = {24'h0, wrote_q, dben_q, st_q != H_IDLE};
				OFS_IRQ_STAT: prdata_d = {29'h0, ist_q};
				OFS_IRQ_MASK: prdata_d = {29'h0, imask_q};
				OFS_HITS:     prdata_d = {26'h0, hits_q};
				default:      prdata_d = 32'h0000_0000;
			endcase
		end
		if (wr) begin
			case (paddr)
				OFS_CTRL:     gen_d   = pwdata[0];
				OFS_WDATA:    wdat_d  = pwdata;
				OFS_IRQ_MASK: imask_d = pwdata[2:0];
				default:      ;
			endcase
		end
		case (st_q)
			H_IDLE: begin
				if (wr && paddr == OFS_CMD) begin
					cmd_d = pwdata[4:0];
					st_d  = H_REQ;
				end
			end
			H_REQ: st_d = H_WAIT;
			H_WAIT: begin
				if (link.ack) begin
					rdat_d = link.rdata;
					set[IRQ_DONE] = 1'b1;
					if (cmd_q[CMD_WR_BIT] && cmd_q[CMD_SEL_BIT] && cmd_q[2:0] < 3'(NUM_BP))
						wrote_d[cmd_q[2:0]] = 1'b1;
					st_d = H_IDLE;
				end
			end
			default: st_d = H_IDLE;
		endcase
		if (wr && paddr == OFS_CMD && st_q != H_IDLE)
			set[IRQ_REFUSED] = 1'b1;
		set[IRQ_HIT] = link.event_hit;
		// Set beats a write-one clear in the same cycle.
		ist_d = (wr && paddr == OFS_IRQ_STAT) ? ((ist_q & ~pwdata[2:0]) | set) : (ist_q | set);
		irq_d = |(ist_d & imask_d);
		// Global enable waits until every enable bit has been written once.
		dben_d = gen_d && (&wrote_d);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			st_q     <= H_IDLE;
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			err_q    <= 1'b0;
			gen_q    <= 1'b0;
			cmd_q    <= 5'h00;
			wdat_q   <= 32'h0000_0000;
			rdat_q   <= 32'h0000_0000;
			ist_q    <= 3'h0;
			imask_q  <= 3'h0;
			hits_q   <= 6'h00;
			wrote_q  <= 6'h00;
			irq_q    <= 1'b0;
			dben_q   <= 1'b0;
		end else begin
			st_q     <= st_d;
			pready_q <= pready_d;
			prdata_q <= prdata_d;
			err_q    <= err_d;
			gen_q    <= gen_d;
			cmd_q    <= cmd_d;
			wdat_q   <= wdat_d;
			rdat_q   <= rdat_d;
			ist_q    <= ist_d;
			imask_q  <= imask_d;
			hits_q   <= hits_d;
			wrote_q  <= wrote_d;
			irq_q    <= irq_d;
			dben_q   <= dben_d;
		end
	end

	assign pready     = pready_q;
	assign prdata     = prdata_q;
	assign pslverr    = err_q;
	assign irq        = irq_q;
	assign link.req   = (st_q == H_REQ);
	assign link.we    = cmd_q[CMD_WR_BIT];
	assign link.sel   = cmd_q[CMD_SEL_BIT];
	assign link.idx   = cmd_q[2:0];
	assign link.wdata = cmd_q[CMD_SEL_BIT] ? legal(wdat_q) : wdat_q;
	assign link.dbg_en = dben_q;
endmodule

/* rtl/bp_pkg.sv */
// Shared constants, field layout and types for the breakpoint unit and its debugger.
package bp_pkg;
	// ----------------------------------------------------------------
	// Breakpoint register pairs
	// ----------------------------------------------------------------
	localparam int          NUM_BP        = 6;
	localparam int          TYPE_LSB      = 20;
	localparam int          MASK_LSB      = 24;
	localparam int          LINK_LSB      = 16;
	localparam int          SEC_LSB       = 14;
	localparam int          HYP_BIT       = 13;
	localparam int          LANE_LSB      = 5;
	localparam int          PRIV_LSB      = 1;
	localparam int          EN_BIT        = 0;
	localparam logic [31:0] CTRL_IMPL     = 32'h1FFF_E1E7;
	localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
	localparam logic [31:0] VALUE_RST     = 32'h0000_0000;
	localparam logic [3:0]  TYPE_ADDR     = 4'h0;
	localparam logic [3:0]  TYPE_LADDR    = 4'h1;
	localparam logic [3:0]  TYPE_CTX      = 4'h2;
	localparam logic [3:0]  TYPE_LCTX     = 4'h3;
	localparam logic [3:0]  TYPE_MIS      = 4'h4;
	localparam logic [3:0]  TYPE_LMIS     = 4'h5;

	// ----------------------------------------------------------------
	// Debugger APB registers
	// ----------------------------------------------------------------
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_CMD       = 8'h04;
	localparam logic [7:0]  OFS_WDATA     = 8'h08;
	localparam logic [7:0]  OFS_RDATA     = 8'h0C;
	localparam logic [7:0]  OFS_STATUS    = 8'h10;
	localparam logic [7:0]  OFS_IRQ_STAT  = 8'h14;
	localparam logic [7:0]  OFS_IRQ_MASK  = 8'h18;
	localparam logic [7:0]  OFS_HITS      = 8'h1C;
	localparam int          CMD_SEL_BIT   = 3;
	localparam int          CMD_WR_BIT    = 4;
	localparam int          IRQ_DONE      = 0;
	localparam int          IRQ_HIT       = 1;
	localparam int          IRQ_REFUSED   = 2;

	typedef enum logic [1:0] {H_IDLE, H_REQ, H_WAIT} host_state_e;

	function automatic logic [3:0] bp_type(input logic [31:0] c);
		return c[TYPE_LSB +: 4];
	endfunction

	function automatic logic is_linked_addr(input logic [31:0] c);
		return (bp_type(c) == TYPE_LADDR) || (bp_type(c) == TYPE_LMIS);
	endfunction
endpackage

/* rtl/bp_link_if.sv */
// Link between the debugger controller and the breakpoint unit.
`timescale 1ns/1ps
interface bp_link_if (
	input wire logic clk
);
	logic        req;
	logic        we;
	logic        sel;
	logic [2:0]  idx;
	logic [31:0] wdata;
	logic        ack;
	logic [31:0] rdata;
	logic        dbg_en;
	logic        event_hit;
	logic [5:0]  hits;

	modport dev (
		input  req, we, sel, idx, wdata, dbg_en,
		output ack, rdata, event_hit, hits
	);
	modport host (
		output req, we, sel, idx, wdata, dbg_en,
		input  ack, rdata, event_hit, hits
	);
endinterface

/* rtl/bp_match.sv */
// Comparator and mode qualifier for one breakpoint register pair.
`timescale 1ns/1ps
module bp_match
	import bp_pkg::*;
(
	// Programmed pair
	input  wire logic [31:0] ctrl,
	input  wire logic [31:0] value,
	// Core state
	input  wire logic [31:0] addr,
	input  wire logic [31:0] ctx_id,
	input  wire logic        thumb_state_bit,
	input  wire logic        jazelle_state_bit,
	input  wire logic        secure,
	input  wire logic        hyp,
	input  wire logic        priv,
	// Results
	output logic             addr_hit,
	output logic             ctx_hit,
	output logic             mode_ok
);
	logic [3:0] lanes;
	logic [1:0] sec;
	logic [1:0] pcond;
	logic [1:0] lane;
	logic       sec_ok;
	logic       lvl_ok;

	assign lanes = ctrl[LANE_LSB +: 4];
	assign sec   = ctrl[SEC_LSB +: 2];
	assign pcond = ctrl[PRIV_LSB +: 2];

	// The mask field is never consulted: no address range masking exists.
	always_comb begin
		if (jazelle_state_bit)
			lane = addr[1:0];
		else if (thumb_state_bit)
			lane = {addr[1], 1'b0};
		else
			lane = 2'h0;
	end

	assign addr_hit = (addr[31:2] == value[31:2]) && lanes[lane];
	assign ctx_hit  = (ctx_id == value);

	// Security condition: both states, non-secure only, secure only.
	assign sec_ok   = (sec == 2'h1) ? !secure : (sec == 2'h2) ? secure : 1'b1;
	// In hyp mode only the hyp condition counts.
	assign lvl_ok   = hyp ? ctrl[HYP_BIT] : (priv ? pcond[0] : pcond[1]);
	assign mode_ok  = sec_ok && lvl_ok;
endmodule

/* rtl/bp_unit.sv */
// Breakpoint unit: six register pairs compared against the core fetch stream.
`timescale 1ns/1ps

// Summary of operation
// - Debugger loads link with context breakpoint index.
// - Debugger zeroes link for unlinked types.
// - Inconsistent link reads unknown, events unpredictable.
// - Security field qualifies matching on security state.
// - Debugger zeroes security field for linked context.
// - Debugger clears hyp bit for linked context.
// - Byte lanes restrict address compare per state.
// - Debugger sets all lanes for context/mask.
// - Privilege field qualifies; linked context needs both.
// - Privilege field ignored while in hyp mode.
// - Bit zero enables; disabled never raises events.
// - Debugger writes enable before global enable.
// - Six pairs of value and control registers.
// - Mask field has no masking effect.
module bp_unit
	import bp_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Debugger link
	bp_link_if.dev           link,
	// Core fetch and mode state
	input  wire logic        fetch_valid,
	input  wire logic [31:0] fetch_addr,
	input  wire logic [31:0] ctx_id,
	input  wire logic        thumb_state_bit,
	input  wire logic        jazelle_state_bit,
	input  wire logic        core_secure,
	input  wire logic        core_hyp,
	input  wire logic        core_priv,
	// Debug events to the core
	output logic             bp_event,
	output logic [5:0]       bp_hit
);
	// ----------------------------------------------------------------
	// Register pairs
	// ----------------------------------------------------------------
	// Control words arrive already legal from the controller; this side still
	// guards reads and firing against an inconsistent link.
	logic [31:0] ctrl_q [NUM_BP];
	logic [31:0] ctrl_d [NUM_BP];
	logic [31:0] val_q  [NUM_BP];
	logic [31:0] val_d  [NUM_BP];
	logic        ack_q;
	logic        ack_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic        event_q;
	logic        event_d;
	logic [5:0]  hit_q;
	logic [5:0]  hit_d;

	logic [NUM_BP-1:0] addr_hit;
	logic [NUM_BP-1:0] ctx_hit;
	logic [NUM_BP-1:0] mode_ok;
	logic [NUM_BP-1:0] link_ok;
	logic [NUM_BP-1:0] link_ctx;
	logic [NUM_BP-1:0] fire;
	logic [NUM_BP-1:0] armed;
	logic              idx_ok;

	// ----------------------------------------------------------------
	// Comparators
	// ----------------------------------------------------------------
	// One comparator per pair; all of them share the same core state.
	genvar g;
	generate
		for (g = 0; g < NUM_BP; g++) begin : g_bp
			bp_match u_match (
				.ctrl              (ctrl_q[g]),
				.value             (val_q[g]),
				.addr              (fetch_addr),
				.ctx_id            (ctx_id),
				.thumb_state_bit   (thumb_state_bit),
				.jazelle_state_bit (jazelle_state_bit),
				.secure            (core_secure),
				.hyp               (core_hyp),
				.priv              (core_priv),
				.addr_hit          (addr_hit[g]),
				.ctx_hit           (ctx_hit[g]),
				.mode_ok           (mode_ok[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Link consistency
	// ----------------------------------------------------------------
	// A link is only trusted when it names an existing pair that is set up
	// for linked context match; anything else is treated as no match, which
	// is one safe outcome of an otherwise undefined programming.
	always_comb begin
		logic [3:0] ln;
		ln = 4'h0;
		for (int i = 0; i < NUM_BP; i++) begin
			ln          = ctrl_q[i][LINK_LSB +: 4];
			link_ok[i]  = 1'b0;
			link_ctx[i] = 1'b0;
			if (is_linked_addr(ctrl_q[i])) begin
				if (ln < 4'(NUM_BP)) begin
					link_ok[i]  = (bp_type(ctrl_q[ln[2:0]]) == TYPE_LCTX);
					link_ctx[i] = ctx_hit[ln[2:0]];
				end
			end else begin
				link_ok[i] = (ln == 4'h0);
			end
		end
	end

	// ----------------------------------------------------------------
	// Event generation
	// ----------------------------------------------------------------
	// Compares run on the registered control words, so a rewrite acts
	// from the first fetch after the write has landed.
	always_comb begin
		logic m;
		m = 1'b0;
		for (int i = 0; i < NUM_BP; i++) begin
			case (bp_type(ctrl_q[i]))
				TYPE_ADDR:  m = addr_hit[i];
				TYPE_MIS:   m = !addr_hit[i];
				TYPE_LADDR: m = addr_hit[i] && link_ctx[i];
				TYPE_LMIS:  m = !addr_hit[i] && link_ctx[i];
				TYPE_CTX:   m = ctx_hit[i];
				default:    m = 1'b0;
			endcase
			// Disabled pairs and globally disabled debug never fire.
			armed[i] = link_ok[i] && mode_ok[i] && ctrl_q[i][EN_BIT];
			fire[i]  = m && armed[i] && fetch_valid && link.dbg_en;
		end
	end

	// Indexes six and seven name no pair: writes are dropped, reads return zero.
	assign idx_ok = (link.idx < 3'(NUM_BP));

	// ----------------------------------------------------------------
	// Register access and output staging
	// ----------------------------------------------------------------
	// Every request is acknowledged, even one to a missing pair, so the
	// controller never waits for an answer that cannot come.
	always_comb begin
		for (int i = 0; i < NUM_BP; i++) begin
			ctrl_d[i] = ctrl_q[i];
			val_d[i]  = val_q[i];
		end
		ack_d   = link.req;
		rdata_d = rdata_q;
		hit_d   = fire;
		event_d = |fire;
		if (link.req) begin
			rdata_d = 32'h0000_0000;
			if (idx_ok && link.we) begin
				if (link.sel)
					ctrl_d[link.idx] = link.wdata & CTRL_IMPL;
				else
					val_d[link.idx] = link.wdata;
			end else if (idx_ok) begin
				if (link.sel) begin
					rdata_d = ctrl_q[link.idx] & CTRL_IMPL;
					// A link field that cannot be honoured reads as zero.
					if (!link_ok[link.idx])
						rdata_d[LINK_LSB +: 4] = 4'h0;
				end else begin
					rdata_d = val_q[link.idx];
				end
			end
		end
	end

	// Control words reset to zero, so every pair starts disabled rather than unknown.
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < NUM_BP; i++) begin
				ctrl_q[i] <= CTRL_RST;
				val_q[i]  <= VALUE_RST;
			end
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
			event_q <= 1'b0;
			hit_q   <= 6'h00;
		end else begin
			for (int i = 0; i < NUM_BP; i++) begin
				ctrl_q[i] <= ctrl_d[i];
				val_q[i]  <= val_d[i];
			end
			ack_q   <= ack_d;
			rdata_q <= rdata_d;
			event_q <= event_d;
			hit_q   <= hit_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Every output is a flip-flop, so neither side sees compare glitches.
	assign link.ack       = ack_q;
	assign link.rdata     = rdata_q;
	assign link.event_hit = event_q;
	assign link.hits      = hit_q;
	assign bp_event       = event_q;
	assign bp_hit         = hit_q;
endmodule

/* sim/bp_checker.sv */
// Concurrent checks on the link between the debugger controller and the breakpoint unit.
`timescale 1ns/1ps
module bp_checker
	import bp_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        srst,
	// Link signals
	input wire logic        req,
	input wire logic        we,
	input wire logic        sel,
	input wire logic [2:0]  idx,
	input wire logic [31:0] wdata,
	input wire logic        ack,
	input wire logic [31:0] rdata,
	input wire logic        dbg_en,
	input wire logic        event_hit,
	input wire logic [5:0]  hits
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// ----------------------------------------------------------------
	// Helper logic
	// ----------------------------------------------------------------
	// Control words written since reset; the global enable must wait for all six.
	logic [5:0] wr_q;
	logic [5:0] wr_d;
	always_comb begin
		wr_d = wr_q;
		if (req && we && sel && idx < 3'd6)
			wr_d[idx] = 1'b1;
	end
	always_ff @(posedge clk) begin
		wr_q <= srst ? 6'h00 : wr_d;
	end

	sequence cmd_issue;
		req;
	endsequence
	sequence cmd_answer;
		ack ##1 !ack;
	endsequence

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	ack_follows_req_a: assert property (cmd_issue |=> cmd_answer)
		else $error("link ack missing one cycle after request");
	ack_cause_a: assert property (ack |-> $past(req))
		else $error("link ack without request");
	req_spacing_a: assert property (req |=> !req [*2])
		else $error("link requests closer than three cycles");
	cmd_hold_a: assert property (req |=> $stable({we, sel, idx, wdata}))
		else $error("link command changed before ack");
	rdata_hold_a: assert property (!ack |-> $stable(rdata))
		else $error("link read data changed without ack");
	reserved_zero_a: assert property (ack && $past(!we && sel) |-> (rdata & ~CTRL_IMPL) == 32'h0)
		else $error("reserved control bits read nonzero");
	bad_index_a: assert property (ack && $past(!we && idx > 3'd5) |-> rdata == 32'h0)
		else $error("read of missing pair not zero");
	hit_flag_a: assert property ((hits != 6'h00) == event_hit)
		else $error("event flag disagrees with hit vector");
	no_hit_off_a: assert property (!$past(dbg_en) && !$past(dbg_en, 2) |-> hits == 6'h00)
		else $error("hit while debug disabled");
	enable_order_a: assert property ($rose(dbg_en) |-> ##[0:2] (&wr_q))
		else $error("global enable before all control words written");
endmodule

/* sim/testbench.sv */
// Self-checking bench for the breakpoint unit facing its debugger controller.
`timescale 1ns/1ps
module testbench
	import bp_pkg::*;
;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic        irq;
	logic        fetch_valid = 1'b0;
	logic [31:0] fetch_addr = 32'h0;
	logic [31:0] ctx_id = 32'h0;
	logic        thumb_state_bit = 1'b0;
	logic        jazelle_state_bit = 1'b0;
	logic        core_secure = 1'b0;
	logic        core_hyp = 1'b0;
	logic        core_priv = 1'b0;
	logic        bp_event;
	logic [5:0]  bp_hit;
	logic [31:0] r;
	logic        e;
	int          miscompares = 0;
	int          checked = 0;

	always #2.5 clk = ~clk;

	bp_link_if  link (.clk(clk));
	bp_unit     i_bp_unit (.clk, .srst, .link(link), .fetch_valid, .fetch_addr, .ctx_id, .thumb_state_bit,
		.jazelle_state_bit, .core_secure, .core_hyp, .core_priv, .bp_event, .bp_hit);
	bp_debugger i_bp_debugger (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .irq, .link(link));
	bp_checker  i_bp_checker (.clk, .srst, .req(link.req), .we(link.we), .sel(link.sel), .idx(link.idx),
		.wdata(link.wdata), .ack(link.ack), .rdata(link.rdata), .dbg_en(link.dbg_en),
		.event_hit(link.event_hit), .hits(link.hits));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// The master waits on pready with no assumed latency.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic bp_cmd(input logic w, input logic [2:0] i, input logic s);
		apb(1'b1, OFS_CMD, {27'h0, w, s, i});
		do begin
			apb(1'b0, OFS_STATUS, 32'h0);
		end while (r[0] !== 1'b0);
		if (!w)
			apb(1'b0, OFS_RDATA, 32'h0);
	endtask

	task automatic bpw(input logic [2:0] i, input logic s, input logic [31:0] d);
		apb(1'b1, OFS_WDATA, d);
		bp_cmd(1'b1, i, s);
	endtask

	task automatic fetch(input logic [31:0] a, input logic [3:0] m, input logic [31:0] c);
		@(posedge clk);
		fetch_valid <= 1'b1;
		fetch_addr <= a;
		ctx_id <= c;
		{thumb_state_bit, core_secure, core_hyp, core_priv} <= m;
		@(posedge clk);
		fetch_valid <= 1'b0;
		#1;
		r = {26'h0, bp_hit};
	endtask

	function automatic logic [31:0] ctl(input logic [3:0] t, input logic [3:0] l, input logic [1:0] s,
		input logic h, input logic [3:0] b, input logic [1:0] p);
		return {8'h00, t, l, s, h, 4'h0, b, 2'h0, p, 1'b1};
	endfunction

	function automatic logic [31:0] av(input logic [2:0] i);
		return {24'h100000, 1'b0, i, 4'h0};
	endfunction

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(r, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk({r[30:0], e}, 32'h1);
		chk({31'h0, irq}, 32'h0);
	endtask

	task automatic t_program();
		apb(1'b1, OFS_CTRL, 32'h1);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(r, 32'h0);
		for (int i = 0; i < 6; i++) begin
			bpw(3'(i), 1'b0, av(3'(i)));
			bpw(3'(i), 1'b1, ctl(TYPE_ADDR, 4'h0, 2'h0, 1'b0, 4'hF, 2'h3));
		end
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(r, 32'hFE);
		bp_cmd(1'b0, 3'd0, 1'b0);
		chk(r, av(3'd0));
		bp_cmd(1'b0, 3'd6, 1'b0);
		chk(r, 32'h0);
	endtask

	task automatic t_pairs();
		for (int i = 0; i < 6; i++) begin
			fetch(av(3'(i)), 4'h1, 32'h0);
			chk(r, 32'h1 << i);
			chk({31'h0, bp_event}, 32'h1);
		end
		bpw(3'd0, 1'b1, ctl(TYPE_ADDR, 4'h0, 2'h0, 1'b0, 4'hF, 2'h3) & ~32'h1);
		fetch(av(3'd0), 4'h1, 32'h0);
		chk(r, 32'h0);
		chk({31'h0, bp_event}, 32'h0);
	endtask

	// Secure-only, hyp allowed, privileged only: hyp fetches ignore the privilege bits.
	task automatic t_modes();
		logic [3:0]  m [4];
		logic [31:0] x [4];
		m = '{4'h1, 4'h5, 4'h4, 4'h6};
		x = '{32'h0, 32'h2, 32'h0, 32'h2};
		bpw(3'd1, 1'b1, ctl(TYPE_ADDR, 4'h0, 2'h2, 1'b1, 4'hF, 2'h1));
		for (int k = 0; k < 4; k++) begin
			fetch(av(3'd1), m[k], 32'h0);
			chk(r, x[k]);
		end
	endtask

	task automatic t_lanes();
		bpw(3'd2, 1'b1, ctl(TYPE_ADDR, 4'h0, 2'h0, 1'b0, 4'h4, 2'h3));
		fetch(av(3'd2) + 32'h2, 4'h9, 32'h0);
		chk(r, 32'h4);
		fetch(av(3'd2), 4'h9, 32'h0);
		chk(r, 32'h0);
		fetch(av(3'd2), 4'h1, 32'h0);
		chk(r, 32'h0);
	endtask

	// An illegal context word is written first; the controller must store the legal form.
	task automatic t_link();
		bpw(3'd4, 1'b0, 32'hC0DE0001);
		bpw(3'd4, 1'b1, ctl(TYPE_LCTX, 4'h0, 2'h1, 1'b1, 4'h0, 2'h0));
		bp_cmd(1'b0, 3'd4, 1'b1);
		chk(r, ctl(TYPE_LCTX, 4'h0, 2'h0, 1'b0, 4'hF, 2'h3));
		bpw(3'd3, 1'b1, ctl(TYPE_LADDR, 4'h4, 2'h0, 1'b0, 4'hF, 2'h3));
		fetch(av(3'd3), 4'h1, 32'hC0DE0001);
		chk(r, 32'h8);
		apb(1'b0, OFS_HITS, 32'h0);
		chk(r, 32'h8);
		fetch(av(3'd3), 4'h1, 32'h0);
		chk(r, 32'h0);
		bpw(3'd3, 1'b1, ctl(TYPE_LADDR, 4'h5, 2'h0, 1'b0, 4'hF, 2'h3));
		bp_cmd(1'b0, 3'd3, 1'b1);
		chk(r, ctl(TYPE_LADDR, 4'h0, 2'h0, 1'b0, 4'hF, 2'h3));
		fetch(av(3'd3), 4'h1, 32'hC0DE0001);
		chk(r, 32'h0);
	endtask

	task automatic t_irq();
		apb(1'b0, OFS_IRQ_STAT, 32'h0);
		chk(r, 32'h3);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, OFS_IRQ_MASK, 32'h2);
		@(posedge clk);
		#1;
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, OFS_IRQ_STAT, 32'h2);
		@(posedge clk);
		#1;
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, OFS_IRQ_STAT, 32'h0);
		chk(r, 32'h1);
	endtask

	task automatic t_reserved();
		bpw(3'd5, 1'b1, 32'hFFFFFFFF);
		bp_cmd(1'b0, 3'd5, 1'b1);
		chk(r, 32'h1FF0E1E7);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_program();
		t_pairs();
		t_modes();
		t_lanes();
		t_link();
		t_irq();
		t_reserved();
		give_verdict();
	end

	// The whole sequence needs about four hundred cycles; this allows some twenty-five times that.
	initial begin
		#50000;
		miscompares++;
		give_verdict();
	end
endmodule
